// *** hw/fbes_host.sv ***
// Functional notes
// - an erase begins with a write of the setup code to an address inside the target block.
// - the confirm code follows at an address in the same block and starts the erase there.
// - status bit 7 high means the write engine is ready; polling goes on while it is low.
// - the status byte only refreshes on a chip-select or output-enable toggle between reads.
// - after bit 1 or bit 3 is set no further erase is allowed until they are cleared.
// - after an error the flags are cleared before any retry or recovery; here only bits 1 and 3 block a new erase, bits 4 and 5 do not.
// - the full error check may follow each erase or a whole series of them.
// - after the last erase the read-array code returns the device to array reads.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
module fbes_host #(
    parameter int ADDR_W = 20
) (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [31:0]       reg_rdata_out,
    output logic                   busy_out,
    output logic      [ADDR_W-1:0] flash_addr_out,
    input  wire logic [7:0]        flash_dq_in,
    output logic      [7:0]        flash_dq_out,
    output logic                   flash_dq_oe_n_out,
    output logic                   flash_ce_n_out,
    output logic                   flash_oe_n_out,
    output logic                   flash_we_n_out
);

    // ****************************************************************
    // types and helpers
    // ****************************************************************
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_WR     = 5'b00010,
        S_WR_REC = 5'b00100,
        S_RD     = 5'b01000,
        S_RD_REC = 5'b10000
    } fbes_state_t;

    typedef enum logic [1:0] {
        STEP_SETUP   = 2'h0,
        STEP_CONFIRM = 2'h1,
        STEP_CMD     = 2'h2
    } fbes_step_t;

    // block number: eight parameter blocks, then one per 64 KB
    function automatic logic [7:0] fbes_block(input logic [ADDR_W-1:0] a);
        logic [7:0] main_idx;
        main_idx = 8'(a >> fbes_pkg::MAIN_BLOCK_LSB);
        if (main_idx == 8'h00)
            fbes_block = 8'(a >> fbes_pkg::PARAM_BLOCK_LSB);
        else
            fbes_block = main_idx + 8'(fbes_pkg::PARAM_BLOCKS - 1);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    fbes_state_t       state_r;
    fbes_step_t        step_r;
    logic [3:0]        cnt_r;
    logic [ADDR_W-1:0] addr_cfg_r;
    logic [7:0]        block_r;
    logic [7:0]        stat_r;
    logic              supply_r;
    logic              seqerr_r;
    logic              efail_r;
    logic              locked_r;
    logic              hold_r;
    logic              refused_r;
    logic              clr_pend_r;
    logic [31:0]       rdata_r;
    logic [ADDR_W-1:0] faddr_r;
    logic [7:0]        fdq_r;
    logic              fdq_oe_n_r;
    logic              fce_n_r;
    logic              foe_n_r;
    logic              fwe_n_r;

    logic [7:0]        dq_sync;
    logic              dq_stable;

    fbes_sync3 #(
        .W (8)
    ) u_dq_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .d_in       (flash_dq_in),
        .q_out      (dq_sync),
        .stable_out (dq_stable)
    );

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire idle      = (state_r == S_IDLE);
    wire wr_ctrl   = reg_wr_in && (reg_addr_in == fbes_pkg::OFS_CTRL);
    wire wr_addr   = reg_wr_in && (reg_addr_in == fbes_pkg::OFS_ADDR);
    wire go_erase  = wr_ctrl && reg_wdata_in[fbes_pkg::CTRL_ERASE_BIT];
    wire go_clear  = wr_ctrl && reg_wdata_in[fbes_pkg::CTRL_CLEAR_BIT];
    wire go_array  = wr_ctrl && reg_wdata_in[fbes_pkg::CTRL_ARRAY_BIT];
    wire start_ers = idle && go_erase && !hold_r;
    wire refuse    = idle && go_erase && hold_r;
    wire start_cmd = idle && !go_erase && (go_clear || go_array);
    wire cnt_done  = (cnt_r == 4'h0);

    // status byte classification
    wire st_seq   = stat_r[fbes_pkg::ERASE_FAIL_FLAG]
                  && stat_r[fbes_pkg::PROGRAM_FAIL_FLAG];
    wire st_efail = stat_r[fbes_pkg::ERASE_FAIL_FLAG] && !st_seq;
    wire st_sup   = stat_r[fbes_pkg::SUPPLY_LOW_FLAG];
    wire st_lock  = stat_r[fbes_pkg::LOCKED_BLOCK_FLAG];

    wire [31:0] status_word =
        (32'(state_r != S_IDLE) << fbes_pkg::ST_BUSY_BIT)
      | (32'(refused_r)         << fbes_pkg::ST_REFUSED_BIT)
      | (32'(hold_r)            << fbes_pkg::ST_HOLD_BIT)
      | (32'(stat_r)            << fbes_pkg::ST_BYTE_LSB)
      | (32'(supply_r)          << fbes_pkg::ST_SUPPLY_BIT)
      | (32'(seqerr_r)          << fbes_pkg::ST_SEQERR_BIT)
      | (32'(efail_r)           << fbes_pkg::ST_EFAIL_BIT)
      | (32'(locked_r)          << fbes_pkg::ST_LOCKED_BIT)
      | (32'(block_r)           << fbes_pkg::ST_BLOCK_LSB);

    wire [31:0] rd_mux =
        (reg_addr_in == fbes_pkg::OFS_ADDR)   ? 32'(addr_cfg_r) :
        (reg_addr_in == fbes_pkg::OFS_STATUS) ? status_word     :
                                                32'h00000000;

    // ****************************************************************
    // software side registers
    // ****************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            addr_cfg_r <= ADDR_W'(fbes_pkg::RST_ADDR);
            rdata_r    <= 32'h00000000;
        end else begin
            if (wr_addr)
                addr_cfg_r <= reg_wdata_in[ADDR_W-1:0];
            rdata_r <= reg_rd_in ? rd_mux : 32'h00000000;
        end
    end

    // ****************************************************************
    // accumulated error flags
    // ****************************************************************
    wire poll_end = (state_r == S_RD_REC) && cnt_done
                  && stat_r[fbes_pkg::ENGINE_READY_FLAG];
    wire clr_done = (state_r == S_WR_REC) && cnt_done
                  && (step_r == STEP_CMD) && clr_pend_r;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            supply_r  <= 1'b0;
            seqerr_r  <= 1'b0;
            efail_r   <= 1'b0;
            locked_r  <= 1'b0;
            hold_r    <= 1'b0;
            refused_r <= 1'b0;
        end else if (clr_done) begin
            // flags cleared together with the device's own sticky bits
            supply_r  <= 1'b0;
            seqerr_r  <= 1'b0;
            efail_r   <= 1'b0;
            locked_r  <= 1'b0;
            hold_r    <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            if (refuse)
                refused_r <= 1'b1;
            if (poll_end) begin
                // flags accumulate over a series of erases
                supply_r <= supply_r | st_sup;
                seqerr_r <= seqerr_r | st_seq;
                efail_r  <= efail_r | st_efail;
                locked_r <= locked_r | st_lock;
                hold_r   <= hold_r | st_sup | st_lock;
            end
        end
    end

    // ****************************************************************
    // flash bus sequencer
    // ****************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_r    <= S_IDLE;
            step_r     <= STEP_SETUP;
            cnt_r      <= 4'h0;
            block_r    <= 8'h00;
            stat_r     <= fbes_pkg::RST_STAT;
            clr_pend_r <= 1'b0;
            faddr_r    <= '0;
            fdq_r      <= 8'h00;
            fdq_oe_n_r <= 1'b1;
            fce_n_r    <= 1'b1;
            foe_n_r    <= 1'b1;
            fwe_n_r    <= 1'b1;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start_ers) begin
                        faddr_r    <= addr_cfg_r;
                        block_r    <= fbes_block(addr_cfg_r);
                        fdq_r      <= fbes_pkg::CMD_ERASE_SETUP;
                        step_r     <= STEP_SETUP;
                        fdq_oe_n_r <= 1'b0;
                        fce_n_r    <= 1'b0;
                        fwe_n_r    <= 1'b0;
                        cnt_r      <= 4'(fbes_pkg::WP_CYC - 1);
                        state_r    <= S_WR;
                    end else if (start_cmd) begin
                        // clear wins when both are asked; read-array is then not issued
                        clr_pend_r <= go_clear;
                        fdq_r      <= go_clear ? fbes_pkg::CMD_CLEAR_STATUS
                                               : fbes_pkg::CMD_READ_ARRAY;
                        step_r     <= STEP_CMD;
                        fdq_oe_n_r <= 1'b0;
                        fce_n_r    <= 1'b0;
                        fwe_n_r    <= 1'b0;
                        cnt_r      <= 4'(fbes_pkg::WP_CYC - 1);
                        state_r    <= S_WR;
                    end
                end
                S_WR: begin
                    if (cnt_done) begin
                        fwe_n_r <= 1'b1;
                        fce_n_r <= 1'b1;
                        cnt_r   <= 4'(fbes_pkg::WPH_CYC - 1);
                        state_r <= S_WR_REC;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                S_WR_REC: begin
                    if (!cnt_done) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (step_r == STEP_SETUP) begin
                        // same address keeps the confirm in the same block
                        fdq_r   <= fbes_pkg::CMD_ERASE_CONFIRM;
                        step_r  <= STEP_CONFIRM;
                        fce_n_r <= 1'b0;
                        fwe_n_r <= 1'b0;
                        cnt_r   <= 4'(fbes_pkg::WP_CYC - 1);
                        state_r <= S_WR;
                    end else if (step_r == STEP_CONFIRM) begin
                        // any read now yields the status byte
                        fdq_oe_n_r <= 1'b1;
                        fce_n_r    <= 1'b0;
                        foe_n_r    <= 1'b0;
                        cnt_r      <= 4'(fbes_pkg::ACC_CYC - 1);
                        state_r    <= S_RD;
                    end else begin
                        fdq_oe_n_r <= 1'b1;
                        clr_pend_r <= 1'b0;
                        state_r    <= S_IDLE;
                    end
                end
                S_RD: begin
                    if (!cnt_done) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (dq_stable) begin
                        stat_r  <= dq_sync;
                        // strobes rise so the next read sees fresh status
                        fce_n_r <= 1'b1;
                        foe_n_r <= 1'b1;
                        cnt_r   <= 4'(fbes_pkg::OEH_CYC - 1);
                        state_r <= S_RD_REC;
                    end
                end
                S_RD_REC: begin
                    if (!cnt_done) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (stat_r[fbes_pkg::ENGINE_READY_FLAG]) begin
                        state_r <= S_IDLE;
                    end else begin
                        fce_n_r <= 1'b0;
                        foe_n_r <= 1'b0;
                        cnt_r   <= 4'(fbes_pkg::ACC_CYC - 1);
                        state_r <= S_RD;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic busy_r;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in)
            busy_r <= 1'b0;
        else
            busy_r <= !idle || start_ers || start_cmd;
    end

    assign reg_rdata_out     = rdata_r;
    assign busy_out          = busy_r;
    assign flash_addr_out    = faddr_r;
    assign flash_dq_out      = fdq_r;
    assign flash_dq_oe_n_out = fdq_oe_n_r;
    assign flash_ce_n_out    = fce_n_r;
    assign flash_oe_n_out    = foe_n_r;
    assign flash_we_n_out    = fwe_n_r;

endmodule // fbes_host

// *** hw/fbes_pkg.sv ***
package fbes_pkg;

    // ****************************************************************
    // software register map of the controller
    // ****************************************************************
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_ADDR   = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_ARRAY_BIT = 2;

    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_HOLD_BIT    = 2;
    localparam int ST_BYTE_LSB    = 8;
    localparam int ST_SUPPLY_BIT  = 16;
    localparam int ST_SEQERR_BIT  = 17;
    localparam int ST_EFAIL_BIT   = 18;
    localparam int ST_LOCKED_BIT  = 19;
    localparam int ST_BLOCK_LSB   = 24;

    localparam logic [19:0] RST_ADDR = 20'h00000;
    localparam logic [7:0]  RST_STAT = 8'h00;

    // ****************************************************************
    // device command codes and status byte fields
    // ****************************************************************
    localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;

    localparam int ENGINE_READY_FLAG  = 7;
    localparam int ERASE_FAIL_FLAG    = 5;
    localparam int PROGRAM_FAIL_FLAG  = 4;
    localparam int SUPPLY_LOW_FLAG    = 3;
    localparam int LOCKED_BLOCK_FLAG  = 1;

    // ****************************************************************
    // byte-wide bottom-boot block layout
    // ****************************************************************
    localparam int PARAM_BLOCKS    = 8;
    localparam int PARAM_BLOCK_LSB = 13;
    localparam int MAIN_BLOCK_LSB  = 16;

    // ****************************************************************
    // bus timing
    // ****************************************************************
    localparam int CLK_NS     = 25;
    localparam int T_WP_NS    = 50;
    localparam int T_WPH_NS   = 30;
    localparam int T_ACC_NS   = 100;
    localparam int T_OEH_NS   = 30;
    localparam int SYNC_CYC   = 3;
    localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC    = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int OEH_CYC    = (T_OEH_NS + CLK_NS - 1) / CLK_NS;

endpackage

// *** hw/fbes_sync3.sv ***
module fbes_sync3 #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out,
    output logic              stable_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign q_out      = s3_r;
    assign stable_out = (s2_r == s3_r);

endmodule // fbes_sync3

// *** tb/fbes_flash_model.sv ***
module fbes_flash_model (
    input  wire logic [19:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        data_oe_n_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [2:0]  fault_in,
    input  int               busy_ns_in,
    output logic [7:0]       dq_out,
    output logic             array_mode_out = 1'b1,
    output int               erase_cnt_out = 0,
    output logic [19:0]      last_addr_out = 20'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  sr_r = 8'h00;
    logic [7:0]  out_r = 8'h00;
    logic        setup_r = 1'b0;
    logic [19:0] setup_addr_r = 20'h0;
    time         done_t = 0;
    logic        sel_r = 1'b0;

    function automatic int blk(logic [19:0] a);
        return (a[19:16] == 4'h0) ? int'(a[15:13]) : int'(a[19:16]) + 7;
    endfunction

    // ****************************************************************
    // command decode on the rising write strobe
    // ****************************************************************
    // select is taken just after the write strobe falls; both rise together
    always @(negedge we_n_in) #1 sel_r = !ce_n_in && !data_oe_n_in;

    always @(posedge we_n_in) begin : cmd
        logic was_setup;
        was_setup = setup_r;
        setup_r = 1'b0;
        if (sel_r) begin
            if (data_in == 8'h20) begin
                setup_r = 1'b1;
                setup_addr_r = addr_in;
            end else if (data_in == 8'hd0) begin
                array_mode_out = 1'b0;
                if (!was_setup || blk(addr_in) != blk(setup_addr_r)
                    || fault_in == 3'd4) begin
                    sr_r[5:4] = 2'b11;
                end else if (!(sr_r[1] | sr_r[3])) begin
                    last_addr_out = addr_in;
                    done_t = $time + busy_ns_in;
                    // a locked or failed block is left as it was
                    if (fault_in == 3'd0) erase_cnt_out++;
                    sr_r[1] = sr_r[1] | (fault_in == 3'd1);
                    sr_r[3] = sr_r[3] | (fault_in == 3'd2);
                    sr_r[5] = sr_r[5] | (fault_in == 3'd3);
                end
            end else if (data_in == 8'h50) begin
                sr_r = 8'h00;
            end else if (data_in == 8'hff) begin
                array_mode_out = 1'b1;
            end
        end
    end

    // byte is captured only when chip select or output enable falls
    always @(negedge ce_n_in or negedge oe_n_in)
        out_r = array_mode_out ? addr_in[7:0] ^ 8'h5a
              : {$time >= done_t, sr_r[6:0]};
    // released pins show the inverse of the last byte
    assign dq_out = (!ce_n_in && !oe_n_in) ? out_r : ~out_r;
endmodule // fbes_flash_model

// *** tb/fbes_host_sva.sv ***
module fbes_host_sva #(
    parameter int ADDR_W = 20
) (
    input wire logic              clk_sys_in,
    input wire logic              reset_n_in,
    input wire logic [3:0]        reg_addr_in,
    input wire logic [31:0]       reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [31:0]       reg_rdata_out,
    input wire logic              busy_out,
    input wire logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [7:0]        flash_dq_in,
    input wire logic [7:0]        flash_dq_out,
    input wire logic              flash_dq_oe_n_out,
    input wire logic              flash_ce_n_out,
    input wire logic              flash_oe_n_out,
    input wire logic              flash_we_n_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    // ****************************************************************
    // write cycles and polling
    // ****************************************************************
    sequence s_wr_low;
        (!flash_we_n_out && !flash_ce_n_out && !flash_dq_oe_n_out)[*2];
    endsequence
    sequence s_wr_rec;
        (flash_we_n_out && flash_ce_n_out)[*2];
    endsequence
    sequence s_confirm;
        $fell(flash_we_n_out) && $stable(flash_addr_out)
        && flash_dq_out == fbes_pkg::CMD_ERASE_CONFIRM;
    endsequence

    a_write_cycle: assert property (
        $fell(flash_we_n_out) |-> s_wr_low ##1 s_wr_rec)
        else $error("write cycle shape wrong");
    a_confirm_follows: assert property (
        $rose(flash_we_n_out)
        && $past(flash_dq_out) == fbes_pkg::CMD_ERASE_SETUP
        |-> ##[1:3] s_confirm)
        else $error("confirm missing after setup");
    a_read_quiet: assert property (
        !flash_oe_n_out |-> flash_we_n_out && flash_dq_oe_n_out)
        else $error("pins driven during read");
    a_read_width: assert property (
        $fell(flash_oe_n_out)
        |-> (!flash_oe_n_out && !flash_ce_n_out)[*7])
        else $error("status read too short");
    a_read_gap: assert property (
        $rose(flash_oe_n_out) |-> (flash_oe_n_out && flash_ce_n_out)[*2])
        else $error("no toggle between reads");
    a_poll_again: assert property (
        $rose(flash_oe_n_out) && !$past(flash_dq_in[7])
        |-> ##[1:4] $fell(flash_oe_n_out))
        else $error("polling stopped while busy");
    a_poll_stop: assert property (
        $rose(flash_oe_n_out) && $past(flash_dq_in[7])
        |-> flash_oe_n_out[*4])
        else $error("polling went on after ready");
    a_addr_hold: assert property (
        busy_out && $past(busy_out) |-> $stable(flash_addr_out))
        else $error("address moved during sequence");
    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data without read strobe");
endmodule // fbes_host_sva

bind fbes_host fbes_host_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// *** tb/test_flash_block_erase_sequencer.sv ***
module test_flash_block_erase_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out, rd;
    logic [19:0] flash_addr_out, last_addr;
    logic [7:0]  flash_dq_in, flash_dq_out;
    logic        busy_out, flash_dq_oe_n_out, array_mode;
    logic        flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
    logic [2:0]  fault = 3'd0;
    int          busy_ns = 100;
    int          erase_cnt;
    int          fails = 0, total_checks = 0;
    int          lk = 0, sup = 0, ef = 0, sq = 0, rf = 0, dsr = 0;
    int          blkn = 0, cnt = 0;
    logic [3:0]  offs [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
    logic [19:0] addrs [8] = '{20'h00000, 20'h01fff, 20'h02000, 20'h0e000,
                               20'h0ffff, 20'h10000, 20'hfffff, 20'h0};

    fbes_host u_dut (.*);
    fbes_flash_model u_flash (
        .addr_in(flash_addr_out), .data_in(flash_dq_out),
        .data_oe_n_in(flash_dq_oe_n_out), .ce_n_in(flash_ce_n_out),
        .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
        .fault_in(fault), .busy_ns_in(busy_ns), .dq_out(flash_dq_in),
        .array_mode_out(array_mode), .erase_cnt_out(erase_cnt),
        .last_addr_out(last_addr));

    initial forever #12.5 clk_sys_in = ~clk_sys_in;
    initial begin
        #(25 * 60000);
        fails++;
        finish_test();
    end

    // ****************************************************************
    // bus tasks and reference model
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic reg_read(logic [3:0] a);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask
    task automatic wait_idle();
        repeat (2) @(posedge clk_sys_in);
        for (int i = 0; i < 3000; i++) begin
            reg_read(fbes_pkg::OFS_STATUS);
            if (rd[fbes_pkg::ST_BUSY_BIT] === 1'b0) begin
                check("busy pin", {31'h0, busy_out}, 32'h0);
                return;
            end
        end
        check("idle wait", 32'h1, 32'h0);
    endtask
    function automatic int blk(logic [19:0] a);
        return (a < 20'h10000) ? int'(a[15:13]) : int'(a[19:16]) + 7;
    endfunction
    function automatic logic [31:0] exp_st();
        logic [31:0] w;
        w = 32'h0;
        w[fbes_pkg::ST_REFUSED_BIT] = rf != 0;
        w[fbes_pkg::ST_HOLD_BIT] = (lk | sup) != 0;
        w[fbes_pkg::ST_BYTE_LSB +: 8] = 8'h80 | dsr[7:0];
        w[fbes_pkg::ST_SUPPLY_BIT] = sup != 0;
        w[fbes_pkg::ST_SEQERR_BIT] = sq != 0;
        w[fbes_pkg::ST_EFAIL_BIT] = ef != 0;
        w[fbes_pkg::ST_LOCKED_BIT] = lk != 0;
        w[fbes_pkg::ST_BLOCK_LSB +: 8] = blkn[7:0];
        return w;
    endfunction
    task automatic erase(logic [19:0] a, logic [2:0] f, string nm);
        int hold;
        logic [31:0] msk;
        hold = lk | sup;
        msk = (hold != 0) ? 32'h00ffffff : 32'hffffffff;
        fault   <= f;
        busy_ns <= 25 * $urandom_range(2, 60);
        reg_write(fbes_pkg::OFS_ADDR, {12'h0, a});
        reg_write(fbes_pkg::OFS_CTRL, 32'h1);
        #1 check("busy pin", {31'h0, busy_out}, {31'h0, hold == 0});
        wait_idle();
        if (hold != 0) rf = 1;
        else begin
            blkn = blk(a);
            cnt += (f == 3'd0);
            dsr |= (f == 1) ? 2 : (f == 2) ? 8 : (f == 3) ? 32 : (f == 4) ? 48 : 0;
            lk |= (f == 1);
            sup |= (f == 2);
            ef |= (f == 3);
            sq |= (f == 4);
            if (f != 3'd4) check({nm, " addr"}, last_addr, a);
        end
        check({nm, " status"}, rd & msk, exp_st() & msk);
        check({nm, " count"}, erase_cnt, cnt);
    endtask
    task automatic clear_st();
        reg_write(fbes_pkg::OFS_CTRL, 32'h2);
        wait_idle();
        {lk, sup, ef, sq, rf, dsr} = '0;
        check("clear", rd & 32'h000f0007, 32'h0);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hd7ff));
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        foreach (offs[i]) begin
            reg_read(offs[i]);
            check("reset value", rd, 32'h0);
        end
        $display("test reset done");
        addrs[7] = 20'($urandom_range(0, 32'hfffff));
        foreach (addrs[i]) erase(addrs[i], 3'd0, "map");
        reg_read(fbes_pkg::OFS_ADDR);
        check("addr reg", rd, {12'h0, addrs[7]});
        check("status mode", {31'h0, array_mode}, 32'h0);
        $display("test map done");
        for (int f = 1; f <= 4; f++) begin
            erase(20'h24680, f[2:0], "fault");
            if (f < 3) erase(20'h30000, 3'd0, "refuse");
            else erase(20'h40000, 3'd0, "sticky");
            clear_st();
        end
        $display("test faults done");
        reg_write(fbes_pkg::OFS_CTRL, 32'h4);
        wait_idle();
        check("array mode", {31'h0, array_mode}, 32'h1);
        $display("test read array done");
        finish_test();
    end
endmodule // test_flash_block_erase_sequencer
